// ### bench/setting_link_chk.sv
`timescale 1ns/1ps
module setting_link_chk (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Unit to controller
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [2:0] req_area,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic restart_ack,
  input wire logic [6:0] ack_unit,
  // Controller to unit
  input wire logic resp_valid,
  input wire logic [15:0] resp_rdata,
  input wire logic [95:0] restart_bits
);
  // ----------------------------------------------------------------
  // Link checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  logic [15:0] m_base;
  logic [15:0] n_base;
  logic set_req;
  // Area bases follow the unit number caught at boot
  assign m_base = 16'(16'h4e20 + 16'(ack_unit) * 16'h0064);
  assign n_base = 16'(16'h07d0 + 16'(ack_unit) * 16'h000a);
  assign set_req = req_valid && req_area == 3'h1;
  sequence req_open;
    $rose(req_valid);
  endsequence
  // Bound only holds because the bench memory answers within a few cycles
  sequence answered;
    !resp_valid [*2] ##[0:38] resp_valid;
  endsequence
  chk_resp_bound: assert property (req_open |-> answered)
    else $error("answer late");
  chk_req_hold: assert property (req_valid && !resp_valid |=> req_valid
    && $stable(req_addr) && $stable(req_wdata) && $stable(req_write))
    else $error("request moved");
  chk_one_word: assert property (resp_valid |-> req_valid ##1 !req_valid && !resp_valid)
    else $error("answer not single");
  chk_write_zero: assert property (resp_valid && req_write |-> resp_rdata == 16'h0000)
    else $error("write answer data");
  chk_set_range: assert property (set_req |-> req_addr >= m_base
    && req_addr <= 16'(m_base + 16'h0063)) else $error("setting address");
  chk_cyc_range: assert property (req_valid && req_area == 3'h2 |-> req_write
    && req_addr >= n_base && req_addr <= 16'(n_base + 16'h0009)) else $error("cyclic address");
  chk_cmd_clear: assert property (set_req && req_write && req_addr == m_base
    |-> req_wdata == 16'h0000) else $error("command not cleared");
  chk_ack_cause: assert property (restart_ack |-> restart_bits[ack_unit])
    else $error("ack without bit");
  chk_ack_clear: assert property (restart_ack |=> !restart_ack
    && !restart_bits[$past(ack_unit)]) else $error("bit not cleared");
endmodule // setting_link_chk

// ### bench/test_io_unit_setting_exchange.sv
`timescale 1ns/1ps
module test_io_unit_setting_exchange;
  // ----------------------------------------------------------------
  // Bench state
  // ----------------------------------------------------------------
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic [6:0] unit_number_in = 7'h00;
  logic small_variant_in = 1'b0;
  logic restart_set_in = 1'b0;
  logic [6:0] restart_unit_in = 7'h00;
  logic mem_ack_in = 1'b0;
  logic [15:0] mem_rdata_in = 16'h0000;
  logic [7:0] bad_off_q = 8'h00;
  logic [7:0] core_index_out, set_offset_out;
  logic [15:0] default_word_in, cyclic_word_in, set_word_out, mem_addr_out, mem_wdata_out;
  logic set_strobe_out, set_bad_in, running_out, setting_error_indicator_out;
  logic mem_req_out, mem_write_out;
  logic hold = 1'b1;
  logic rb_mode = 1'b0;
  logic [2:0] mem_area_out;
  logic [2:0] o_area = 3'h3;
  logic [2:0] p_area = 3'h4;
  logic [95:0] restart_bits_out;
  logic [15:0] m, m_next, o_start, p_start;
  logic [6:0] u;
  logic [15:0] mem [logic [18:0]];
  int failures = 0;
  int cmp_count = 0;
  int wait_q = 0;
  int g1_cnt = 0;
  int g2_cnt = 0;
  int exp_cnt = 0;

  always #2 clk_sys_in = ~clk_sys_in;

  // Both ends joined across the link, checker beside it
  setting_link_if link ();
  io_unit_end i_io_unit_end (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .link(link),
    .unit_number_in(unit_number_in), .small_variant_in(small_variant_in),
    .core_index_out(core_index_out), .default_word_in(default_word_in),
    .cyclic_word_in(cyclic_word_in), .set_strobe_out(set_strobe_out),
    .set_offset_out(set_offset_out), .set_word_out(set_word_out), .set_bad_in(set_bad_in),
    .running_out(running_out), .setting_error_indicator_out(setting_error_indicator_out));
  controller_end i_controller_end (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .link(link),
    .restart_set_in(restart_set_in), .restart_unit_in(restart_unit_in),
    .restart_bits_out(restart_bits_out), .mem_req_out(mem_req_out),
    .mem_write_out(mem_write_out), .mem_area_out(mem_area_out), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out), .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in));
  setting_link_chk i_setting_link_chk (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .req_valid(link.req_valid), .req_write(link.req_write), .req_area(link.req_area),
    .req_addr(link.req_addr), .req_wdata(link.req_wdata), .restart_ack(link.restart_ack),
    .ack_unit(link.ack_unit), .resp_valid(link.resp_valid), .resp_rdata(link.resp_rdata),
    .restart_bits(link.restart_bits));

  // Core lookups answer in the same cycle, so they cannot wait for an edge
  assign default_word_in = {core_index_out, 8'h58};
  assign cyclic_word_in = {8'ha5, core_index_out};
  assign set_bad_in = set_strobe_out && bad_off_q != 8'h00 && set_offset_out == bad_off_q;

  function automatic logic [15:0] rd(input logic [2:0] a, input logic [15:0] w);
    return mem.exists({a, w}) ? mem[{a, w}] : 16'h0000;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Sampled on the falling edge, where outputs have settled
  task automatic wait_until(input int what);
    int n;
    n = 0;
    while (n < 5000 && !(what == 0 ? running_out === 1'b1 : what == 1 ?
        setting_error_indicator_out === 1'b1 : link.restart_ack === 1'b1)) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n >= 5000) begin
      failures++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      results();
    end
  endtask

  // Random settings plus expansion pointers for one unit
  task automatic preload(input logic [6:0] pu, input logic [15:0] cmd);
    hold = 1'b1;
    m_next = 16'(16'h4e20 + 16'(pu) * 16'h0064);
    o_start = 16'($urandom_range(28672, 0));
    p_start = 16'($urandom_range(28672, 0));
    for (int k = 1; k < 100; k++) begin
      mem[{3'h1, 16'(m_next + k)}] = 16'($urandom);
    end
    for (int k = 2; k < 46; k++) begin
      mem[{o_area, 16'(o_start + k)}] = 16'($urandom);
    end
    mem[{3'h1, m_next}] = cmd;
    mem[{3'h1, 16'(m_next + 16'h0062)}] = {13'h0, o_area};
    mem[{3'h1, 16'(m_next + 16'h0063)}] = o_start;
    mem[{o_area, o_start}] = {13'h0, p_area};
    mem[{o_area, 16'(o_start + 16'h0001)}] = p_start;
  endtask

  task automatic pulse(input logic [6:0] ru);
    @(posedge clk_sys_in);
    restart_set_in <= 1'b1;
    restart_unit_in <= ru;
    @(posedge clk_sys_in);
    restart_set_in <= 1'b0;
  endtask

  task automatic restart(input logic [6:0] ru, input int what);
    pulse(ru);
    wait_until(2);
    m = m_next;
    g1_cnt = 0;
    g2_cnt = 0;
    exp_cnt = 0;
    hold = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    check({15'h0, restart_bits_out[ru]}, 16'h0000, "restart bit");
    wait_until(what);
    repeat (20) @(negedge clk_sys_in);
  endtask

  // Controller memory answers after a random delay
  always @(posedge clk_sys_in) begin
    mem_ack_in <= 1'b0;
    if (mem_req_out && !mem_ack_in) begin
      if (wait_q == 0) begin
        mem_ack_in <= 1'b1;
        mem_rdata_in <= rd(mem_area_out, mem_addr_out);
        if (mem_write_out) mem[{mem_area_out, mem_addr_out}] = mem_wdata_out;
        wait_q <= int'($urandom_range(3, 0));
      end else begin
        wait_q <= wait_q - 1;
      end
    end
  end

  // Words handed to the core equal what the controller holds
  always @(posedge clk_sys_in) begin
    if (set_strobe_out === 1'b1) begin
      if (set_offset_out < 8'h23) g1_cnt++;
      else if (set_offset_out < 8'h5a) g2_cnt++;
      else if (set_offset_out >= 8'h64 && set_offset_out < 8'h92) exp_cnt++;
      if (!hold && set_offset_out < 8'h64) begin
        check(set_word_out, rd(3'h1, 16'(m + set_offset_out)), "setting");
      end else if (!hold && !rb_mode && set_offset_out < 8'h92) begin
        check(set_word_out, rd(o_area, 16'(o_start + set_offset_out - 8'h64)), "exp");
      end else if (!hold && !rb_mode) begin
        check(set_word_out, rd(p_area, 16'(p_start + set_offset_out - 8'h92)), "cm");
      end
    end
  end

  initial begin
    void'($urandom(19294));
    u = 7'($urandom_range(94, 0));
    unit_number_in <= u;
    preload(u, 16'h0000);
    m = m_next;
    hold = 1'b0;
    repeat (16) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    wait_until(0);
    repeat (2000) @(negedge clk_sys_in);
    check(16'(exp_cnt), 16'h002e, "exp count");
    check(16'(g2_cnt), 16'h0037, "group two count");
    check({15'h0, g1_cnt > 68}, 16'h0001, "group one refresh");
    for (int i = 0; i < 10; i++) begin
      check(rd(3'h2, 16'(16'h07d0 + 16'(u) * 16'h000a + i)), {8'ha5, 8'(i)}, "cyclic");
    end
    $display("test boot done");
    small_variant_in <= 1'b1;
    unit_number_in <= 7'h5f;
    preload(7'h5f, 16'h0000);
    restart(u, 0);
    check(16'(exp_cnt), 16'h0018, "short exp count");
    check(16'(g2_cnt), 16'h0037, "reload");
    pulse(7'h5e);
    repeat (200) @(negedge clk_sys_in);
    check({15'h0, restart_bits_out[94]}, 16'h0001, "other bit kept");
    check(16'(g2_cnt), 16'h0037, "no reboot");
    $display("test restart done");
    bad_off_q <= 8'h05;
    wait_until(1);
    repeat (20) @(negedge clk_sys_in);
    check(rd(3'h1, 16'(m + 16'h005a)), 16'h0005, "group one error");
    check({15'h0, running_out}, 16'h0000, "halted");
    bad_off_q <= 8'h00;
    restart(7'h5f, 0);
    check({15'h0, setting_error_indicator_out}, 16'h0000, "indicator off");
    bad_off_q <= 8'h28;
    restart(7'h5f, 1);
    check(rd(3'h1, 16'(m + 16'h005a)), 16'h0028, "group two error");
    bad_off_q <= 8'h00;
    $display("test errors done");
    rb_mode = 1'b1;
    preload(7'h5f, 16'h3039);
    restart(7'h5f, 0);
    check(16'(g2_cnt), 16'h0000, "no load");
    check(rd(3'h1, m), 16'h0000, "command cleared");
    for (int k = 1; k < 100; k++) begin
      check(rd(3'h1, 16'(m + k)), {8'(k), 8'h58}, "default");
    end
    restart(7'h5f, 0);
    check(16'(g2_cnt), 16'h0037, "normal load");
    $display("test read-back done");
    results();
  end
endmodule // test_io_unit_setting_exchange

// ### include/setting_link_if.sv
`timescale 1ns/1ps
interface setting_link_if;

  // Word request from the unit to the controller memory
  logic req_valid;
  logic req_write;
  logic [2:0] req_area;
  logic [15:0] req_addr;
  logic [15:0] req_wdata;
  // Answer from the controller
  logic resp_valid;
  logic [15:0] resp_rdata;
  // Restart bits, one per unit number, and their acknowledge
  logic [95:0] restart_bits;
  logic restart_ack;
  logic [6:0] ack_unit;

  modport unit_end (
    output req_valid, req_write, req_area, req_addr, req_wdata, restart_ack, ack_unit,
    input resp_valid, resp_rdata, restart_bits
  );

  modport ctrl_end (
    input req_valid, req_write, req_area, req_addr, req_wdata, restart_ack, ack_unit,
    output resp_valid, resp_rdata, restart_bits
  );

endinterface

// ### include/setting_link_pkg.sv
package setting_link_pkg;

  // ----------------------------------------------------------------
  // Word and unit number widths
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int UNIT_W = 7;
  localparam int AREA_W = 3;
  localparam int IDX_W = 8;
  localparam int UNIT_COUNT = 96;
  localparam int RESTART_WORDS = 6;
  localparam int RESTART_BITS = 16;

  // ----------------------------------------------------------------
  // Memory area codes carried on the link
  // ----------------------------------------------------------------
  localparam logic [2:0] AREA_NONE = 3'h0;
  localparam logic [2:0] AREA_SETTING = 3'h1;
  localparam logic [2:0] AREA_CYCLIC = 3'h2;

  // ----------------------------------------------------------------
  // Area placement from the unit number
  // ----------------------------------------------------------------
  localparam logic [15:0] SETTING_BASE = 16'h4e20;
  localparam logic [15:0] SETTING_STRIDE = 16'h0064;
  localparam logic [15:0] CYCLIC_BASE = 16'h07d0;
  localparam logic [15:0] CYCLIC_STRIDE = 16'h000a;

  // ----------------------------------------------------------------
  // Word offsets inside the setting-word area and the cyclic area
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OFF = 8'h00;
  localparam logic [7:0] FIRST_SET_OFF = 8'h01;
  localparam logic [7:0] G1_LAST_OFF = 8'h22;
  localparam logic [7:0] DISP_OFF = 8'h5a;
  localparam logic [7:0] EXP_AREA_OFF = 8'h62;
  localparam logic [7:0] EXP_START_OFF = 8'h63;
  localparam logic [7:0] LAST_SET_OFF = 8'h63;
  localparam logic [7:0] CYCLIC_LAST = 8'h09;

  // ----------------------------------------------------------------
  // Expansion areas and reported offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] EXP_LEN = 8'h2e;
  localparam logic [7:0] EXP_LEN_SMALL = 8'h18;
  localparam logic [7:0] CM_LEN = 8'h23;
  localparam logic [7:0] EXP_REPORT_BASE = 8'h64;
  localparam logic [7:0] CM_REPORT_BASE = 8'h92;

  // ----------------------------------------------------------------
  // Command word values
  // ----------------------------------------------------------------
  localparam logic [15:0] DEFAULT_READ_CMD = 16'h3039;
  localparam logic [15:0] CMD_CLEARED = 16'h0000;

  // Word address of an area member
  function automatic logic [15:0] word_addr(input logic [15:0] base, input logic [7:0] off);
    word_addr = 16'(base + {8'h00, off});
  endfunction

endpackage

// ### verilog/controller_end.sv
`timescale 1ns/1ps
module controller_end (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Link to the units
  setting_link_if.ctrl_end link,
  // Restart bit control from the controller program
  input wire logic restart_set_in,
  input wire logic [6:0] restart_unit_in,
  output logic [95:0] restart_bits_out,
  // Shared word memory
  output logic mem_req_out,
  output logic mem_write_out,
  output logic [2:0] mem_area_out,
  output logic [15:0] mem_addr_out,
  output logic [15:0] mem_wdata_out,
  input wire logic mem_ack_in,
  input wire logic [15:0] mem_rdata_in
);

  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_RESP} state_type;

  state_type state_q;
  logic [15:0] restart_q [setting_link_pkg::RESTART_WORDS];
  logic [95:0] restart_flat;
  logic mem_write_q;
  logic [2:0] mem_area_q;
  logic [15:0] mem_addr_q, mem_wdata_q, rdata_q;

  // ----------------------------------------------------------------
  // Restart words: unit k is bit k mod 16 of word k div 16
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      for (int w = 0; w < setting_link_pkg::RESTART_WORDS; w++) begin
        restart_q[w] <= 16'h0000;
      end
    end else begin
      // Unit acknowledges once it has begun the reload
      if (link.restart_ack) begin
        restart_q[link.ack_unit[6:4]][link.ack_unit[3:0]] <= 1'b0;
      end
      // A new set in the same cycle wins over the clear
      if (restart_set_in) begin
        restart_q[restart_unit_in[6:4]][restart_unit_in[3:0]] <= 1'b1;
      end
    end
  end

  always_comb begin
    for (int w = 0; w < setting_link_pkg::RESTART_WORDS; w++) begin
      restart_flat[w*16 +: 16] = restart_q[w];
    end
  end

  // ----------------------------------------------------------------
  // Word request service against the shared memory
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_q <= ST_IDLE;
      mem_write_q <= 1'b0;
      mem_area_q <= setting_link_pkg::AREA_NONE;
      mem_addr_q <= 16'h0000;
      mem_wdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (link.req_valid) begin
            // Addresses arrive already placed by unit number
            mem_write_q <= link.req_write;
            mem_area_q <= link.req_area;
            mem_addr_q <= link.req_addr;
            mem_wdata_q <= link.req_wdata;
            state_q <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (mem_ack_in) begin
            rdata_q <= mem_write_q ? 16'h0000 : mem_rdata_in;
            state_q <= ST_RESP;
          end
        end
        default: begin
          // One idle cycle lets the unit drop its request first
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign link.restart_bits = restart_flat;
  assign link.resp_valid = (state_q == ST_RESP);
  assign link.resp_rdata = rdata_q;
  assign restart_bits_out = restart_flat;
  assign mem_req_out = (state_q == ST_BUSY);
  assign mem_write_out = mem_write_q;
  assign mem_area_out = mem_area_q;
  assign mem_addr_out = mem_addr_q;
  assign mem_wdata_out = mem_wdata_q;

endmodule // controller_end

// ### verilog/io_unit_end.sv
`timescale 1ns/1ps
module io_unit_end (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Link to the controller
  setting_link_if.unit_end link,
  // Front switches and variant strap
  input wire logic [6:0] unit_number_in,
  input wire logic small_variant_in,
  // Analog core: defaults and operating data by index
  output logic [7:0] core_index_out,
  input wire logic [15:0] default_word_in,
  input wire logic [15:0] cyclic_word_in,
  // Analog core: setting words delivered and checked
  output logic set_strobe_out,
  output logic [7:0] set_offset_out,
  output logic [15:0] set_word_out,
  input wire logic set_bad_in,
  // Status
  output logic running_out,
  output logic setting_error_indicator_out
);

  typedef enum logic [3:0] {
    ST_BOOT, ST_CMD, ST_DFLT, ST_CLR, ST_INIT, ST_EXP,
    ST_RUN_G1, ST_RUN_CYC, ST_RUN_CM, ST_ERR, ST_HALT
  } state_type;

  state_type state_q, nxt_state;
  logic [7:0] idx_q, last_idx, nxt_idx;
  logic pend_q, resp_take, run_state, restart_go;
  logic [6:0] unit_q;
  logic small_q;
  logic [15:0] m_base_q, n_base_q, exp_base_q, cm_base_q;
  logic [2:0] exp_area_q, cm_area_q;
  logic err_pend_q, err_ind_q;
  logic [7:0] err_off_q;
  logic restart_prev_q, restart_req_q, ack_q;
  logic req_valid_q, req_write_q;
  logic [2:0] req_area_q, iss_area;
  logic [15:0] req_addr_q, req_wdata_q, iss_addr, iss_wdata;
  logic iss_write;
  logic set_stb_q;
  logic [7:0] set_off_q;
  logic [15:0] set_word_q;

  assign resp_take = pend_q & link.resp_valid;
  assign run_state = (state_q == ST_RUN_G1) || (state_q == ST_RUN_CYC) ||
                     (state_q == ST_RUN_CM);
  // A restart waits for the open request so no stray answer follows it
  assign restart_go = restart_req_q && !pend_q && (state_q != ST_DFLT) &&
                      (state_q != ST_CLR);

  // ----------------------------------------------------------------
  // Request contents and walk lengths per state
  // ----------------------------------------------------------------
  always_comb begin
    iss_write = 1'b0;
    iss_area = setting_link_pkg::AREA_SETTING;
    iss_addr = setting_link_pkg::word_addr(m_base_q, idx_q);
    iss_wdata = setting_link_pkg::CMD_CLEARED;
    last_idx = setting_link_pkg::LAST_SET_OFF;
    nxt_state = ST_RUN_G1;
    nxt_idx = setting_link_pkg::FIRST_SET_OFF;
    case (state_q)
      ST_CMD: begin
        last_idx = setting_link_pkg::CMD_OFF;
        if (link.resp_rdata == setting_link_pkg::DEFAULT_READ_CMD) begin
          nxt_state = ST_DFLT;
        end else begin
          nxt_state = ST_INIT;
        end
      end
      ST_DFLT: begin
        iss_write = 1'b1;
        iss_wdata = default_word_in;
        nxt_state = ST_CLR;
        nxt_idx = setting_link_pkg::CMD_OFF;
      end
      ST_CLR: begin
        iss_write = 1'b1;
        last_idx = setting_link_pkg::CMD_OFF;
      end
      ST_INIT: begin
        if (exp_area_q != setting_link_pkg::AREA_NONE) begin
          nxt_state = ST_EXP;
          nxt_idx = 8'h00;
        end
      end
      ST_EXP: begin
        iss_area = exp_area_q;
        iss_addr = setting_link_pkg::word_addr(exp_base_q, idx_q);
        last_idx = 8'(small_q ? setting_link_pkg::EXP_LEN_SMALL - 8'h01
                              : setting_link_pkg::EXP_LEN - 8'h01);
      end
      ST_RUN_G1: begin
        last_idx = setting_link_pkg::G1_LAST_OFF;
        nxt_state = ST_RUN_CYC;
        nxt_idx = 8'h00;
      end
      ST_RUN_CYC: begin
        iss_write = 1'b1;
        iss_area = setting_link_pkg::AREA_CYCLIC;
        iss_addr = setting_link_pkg::word_addr(n_base_q, idx_q);
        iss_wdata = cyclic_word_in;
        last_idx = setting_link_pkg::CYCLIC_LAST;
        nxt_state = ST_RUN_CM;
        nxt_idx = 8'h00;
      end
      ST_RUN_CM: begin
        iss_area = cm_area_q;
        iss_addr = setting_link_pkg::word_addr(cm_base_q, idx_q);
        last_idx = 8'(setting_link_pkg::CM_LEN - 8'h01);
      end
      ST_ERR: begin
        iss_write = 1'b1;
        iss_addr = setting_link_pkg::word_addr(m_base_q, setting_link_pkg::DISP_OFF);
        iss_wdata = {8'h00, err_off_q};
        last_idx = 8'h00;
        nxt_state = ST_HALT;
      end
      default: begin
        last_idx = 8'h00;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer: one word request at a time
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_q <= ST_BOOT;
      idx_q <= 8'h00;
      pend_q <= 1'b0;
      req_valid_q <= 1'b0;
      req_write_q <= 1'b0;
      req_area_q <= setting_link_pkg::AREA_NONE;
      req_addr_q <= 16'h0000;
      req_wdata_q <= 16'h0000;
    end else if (restart_go) begin
      state_q <= ST_BOOT;
      idx_q <= 8'h00;
    end else begin
      case (state_q)
        ST_BOOT: begin
          state_q <= ST_CMD;
          idx_q <= setting_link_pkg::CMD_OFF;
        end
        ST_HALT: begin
          idx_q <= 8'h00; // Stopped until power-on or restart
        end
        default: begin
          if (!pend_q) begin
            if (run_state && err_pend_q) begin
              state_q <= ST_ERR;
              idx_q <= 8'h00;
            end else if (state_q == ST_RUN_CM &&
                         cm_area_q == setting_link_pkg::AREA_NONE) begin
              state_q <= ST_RUN_G1; // Control/monitor area not allocated
              idx_q <= setting_link_pkg::FIRST_SET_OFF;
            end else begin
              req_valid_q <= 1'b1;
              pend_q <= 1'b1;
              req_write_q <= iss_write;
              req_area_q <= iss_area;
              req_addr_q <= iss_addr;
              req_wdata_q <= iss_wdata;
            end
          end else if (resp_take) begin
            req_valid_q <= 1'b0;
            pend_q <= 1'b0;
            if (idx_q == last_idx) begin
              state_q <= nxt_state;
              idx_q <= nxt_idx;
            end else begin
              idx_q <= 8'(idx_q + 8'h01);
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Area bases and straps, caught at each boot
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      unit_q <= 7'h00;
      small_q <= 1'b0;
      m_base_q <= setting_link_pkg::SETTING_BASE;
      n_base_q <= setting_link_pkg::CYCLIC_BASE;
    end else if (state_q == ST_BOOT) begin
      unit_q <= unit_number_in;
      small_q <= small_variant_in;
      m_base_q <= 16'(setting_link_pkg::SETTING_BASE +
                      16'(16'(unit_number_in) * setting_link_pkg::SETTING_STRIDE));
      n_base_q <= 16'(setting_link_pkg::CYCLIC_BASE +
                      16'(16'(unit_number_in) * setting_link_pkg::CYCLIC_STRIDE));
    end
  end

  // ----------------------------------------------------------------
  // Expansion pointers, taken once per boot in the normal direction
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || state_q == ST_BOOT) begin
      exp_area_q <= setting_link_pkg::AREA_NONE;
      exp_base_q <= 16'h0000;
      cm_area_q <= setting_link_pkg::AREA_NONE;
      cm_base_q <= 16'h0000;
    end else if (resp_take && state_q == ST_INIT) begin
      if (idx_q == setting_link_pkg::EXP_AREA_OFF) begin
        exp_area_q <= link.resp_rdata[2:0];
      end
      if (idx_q == setting_link_pkg::EXP_START_OFF) begin
        exp_base_q <= link.resp_rdata;
      end
    end else if (resp_take && state_q == ST_EXP) begin
      if (idx_q == 8'h00) begin
        cm_area_q <= link.resp_rdata[2:0];
      end
      if (idx_q == 8'h01) begin
        cm_base_q <= link.resp_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Setting words handed to the analog core
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      set_stb_q <= 1'b0;
      set_off_q <= 8'h00;
      set_word_q <= 16'h0000;
    end else begin
      // Group two and pointers arrive only through the one-shot load
      set_stb_q <= resp_take && (state_q == ST_INIT || state_q == ST_EXP ||
                   state_q == ST_RUN_G1 || state_q == ST_RUN_CM);
      if (resp_take) begin
        set_word_q <= link.resp_rdata;
        if (state_q == ST_EXP) begin
          set_off_q <= 8'(setting_link_pkg::EXP_REPORT_BASE + idx_q);
        end else if (state_q == ST_RUN_CM) begin
          set_off_q <= 8'(setting_link_pkg::CM_REPORT_BASE + idx_q);
        end else begin
          set_off_q <= idx_q;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Range errors: first bad offset kept, indicator lit on report
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      err_pend_q <= 1'b0;
      err_off_q <= 8'h00;
      err_ind_q <= 1'b0;
    end else begin
      if (state_q == ST_BOOT) begin
        err_pend_q <= 1'b0;
        err_ind_q <= 1'b0;
      end
      if (state_q == ST_ERR) begin
        err_ind_q <= 1'b1;
      end
      // Control/monitor words are live data, not settings to range-check
      if (set_stb_q && set_bad_in && !err_pend_q &&
          set_off_q < setting_link_pkg::CM_REPORT_BASE) begin
        err_pend_q <= 1'b1;
        err_off_q <= set_off_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Restart bit: rising edge requests a reload, set wins over take
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      restart_prev_q <= 1'b0;
      restart_req_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      restart_prev_q <= link.restart_bits[unit_q];
      ack_q <= restart_go;
      if (restart_go) begin
        restart_req_q <= 1'b0;
      end
      if (link.restart_bits[unit_q] && !restart_prev_q) begin
        restart_req_q <= 1'b1;
      end
    end
  end

  // Link and core outputs
  assign link.req_valid = req_valid_q;
  assign link.req_write = req_write_q;
  assign link.req_area = req_area_q;
  assign link.req_addr = req_addr_q;
  assign link.req_wdata = req_wdata_q;
  assign link.restart_ack = ack_q;
  assign link.ack_unit = unit_q;
  assign core_index_out = idx_q;
  assign set_strobe_out = set_stb_q;
  assign set_offset_out = set_off_q;
  assign set_word_out = set_word_q;
  assign running_out = run_state;
  assign setting_error_indicator_out = err_ind_q;

endmodule // io_unit_end
